// File: shared/tmr8_pkg.sv
// Constants and types of the 8-bit compare timer.
// Assumes an APB master on pclk and a timer tick from the same clock domain.
//
// Function
// - A count write blocks any compare match during the next timer tick.
// - Compare output state survives any waveform mode change.
// - Output mode is unbuffered and governs the first match after writing.
// - Nonzero output mode puts compare output on the pin; direction bit rules.
// - Output mode zero leaves compare output unchanged at matches.
// - In non-PWM modes the force strobe applies the action like a match.
// - Waveform mode alone sets counting; output mode only sets action.
// - Normal mode only increments and wraps from 0xff to 0x00.
// - Normal mode sets overflow flag as count becomes zero; hardware only sets.
// - Clear-on-match mode clears count at the tick after count equals compare.
// - Clear-on-match compare writes act directly; a low value waits for wrap.
// - Clear-on-match with output mode 1 toggles the output every match.
// - Clear-on-match sets overflow flag when count passes maximum to zero, unless compare equals maximum.
// - Fast PWM counts up to maximum, then clears: period 256 ticks.
// - Fast PWM mode 2 clears at match, sets at wrap; mode 3 inverts.
// - Fast PWM sets overflow flag each time count wraps from maximum to zero.
// - Fast PWM compare zero gives a spike; maximum gives constant level.
// - Fast PWM output mode 1 toggles on match; compare stays double buffered.
// - Waveform mode 1 selects dual-slope phase-correct counting.
// - Compare flag sets at the tick after count equals compare value.
// - PWM modes buffer compare writes until cycle boundary; others bypass.
// - Forced compare sets no flag and never clears or reloads the counter.
package tmr8_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_COUNT   = 8'h04;
    localparam logic [7:0] ADDR_COMPARE = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0c;
    // Control field positions
    localparam int CTRL_WGM_LSB   = 0;
    localparam int CTRL_COM_LSB   = 2;
    localparam int CTRL_FORCE_BIT = 4;
    localparam int CTRL_DIR_BIT   = 5;
    localparam int CTRL_PORT_BIT  = 6;
    // Status field positions
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_CMP_BIT = 1;
    localparam int STAT_OC_BIT  = 2;
    // Count extremes
    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_ONE    = 8'h01;
    // Waveform modes
    typedef enum logic [1:0] {
        TMR8_NORMAL = 2'h0,
        TMR8_PHASE  = 2'h1,
        TMR8_CLEAR  = 2'h2,
        TMR8_FAST   = 2'h3
    } tmr8_wgm_e;
    // Compare output modes
    localparam logic [1:0] COM_NONE   = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;
endpackage : tmr8_pkg

// File: hdl/tmr8_top.sv
// 8-bit up/down timer with one compare channel, waveform generator and APB.
// Assumes timer_tick comes from a prescaler on pclk; the pin wire is
// resolved outside from pin_out and pin_oe_n.
//
// Register access over APB and the address map were decided locally.
module tmr8_top
    import tmr8_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_tick,
    output logic             overflow_flag,
    output logic             compare_flag,
    output logic             compare_output,
    output logic             pin_out,
    output logic             pin_oe_n
);
    import tmr8_pkg::*;

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  cnt;
        logic [7:0]  ocr;
        logic [7:0]  ocb;
        tmr8_wgm_e   wgm;
        logic [1:0]  com;
        logic        dir;
        logic        port;
        logic        oc;
        logic        ovf;
        logic        cmf;
        logic        blk;
        logic        dn;
        logic [31:0] rdata;
    } tmr8_state_s;

    tmr8_state_s st_r;
    tmr8_state_s st_nxt;

    // Non-PWM action of a compare: toggle, clear or set
    function automatic logic tmr8_act(
        input logic [1:0] com,
        input logic       oc
    );
        case (com)
            COM_TOGGLE: tmr8_act = ~oc;
            COM_CLEAR:  tmr8_act = 1'b0;
            COM_SET:    tmr8_act = 1'b1;
            default:    tmr8_act = oc;
        endcase
    endfunction : tmr8_act

    // True in the two PWM modes
    function automatic logic tmr8_pwm(
        input tmr8_wgm_e wgm
    );
        tmr8_pwm = (wgm == TMR8_FAST) || (wgm == TMR8_PHASE);
    endfunction : tmr8_pwm

    //------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------
    logic access;
    logic wr;
    logic mapped;
    logic cw;
    logic kw;
    logic ow;
    logic sw;
    logic force_hit;
    logic match;
    logic top;

    // Access phase and register selects
    assign access = psel && penable;
    assign wr     = access && pwrite;
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_COUNT)
                 || (paddr == ADDR_COMPARE) || (paddr == ADDR_STATUS);
    assign cw     = wr && (paddr == ADDR_COUNT);
    assign kw     = wr && (paddr == ADDR_CTRL);
    assign ow     = wr && (paddr == ADDR_COMPARE);
    assign sw     = wr && (paddr == ADDR_STATUS);
    assign force_hit = kw && pwdata[CTRL_FORCE_BIT];

    // Zero wait states; unmapped access answers with an error
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // Match is suppressed during the tick after a count write
    assign match = (st_r.cnt == st_r.ocr) && !st_r.blk;
    assign top   = (st_r.cnt == CNT_MAX);

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;

        // Flags clear by writing one
        if (sw && pwdata[STAT_OVF_BIT])
        begin
            st_nxt.ovf = 1'b0;
        end
        if (sw && pwdata[STAT_CMP_BIT])
        begin
            st_nxt.cmf = 1'b0;
        end

        // Counting, driven by waveform mode only
        if (timer_tick)
        begin
            st_nxt.blk = 1'b0;
            case (st_r.wgm)
                TMR8_NORMAL:
                begin
                    st_nxt.cnt = st_r.cnt + CNT_ONE;
                    if (top)
                    begin
                        st_nxt.ovf = 1'b1;
                    end
                end
                TMR8_CLEAR:
                begin
                    // A missed low top runs on through the wrap
                    if (match)
                    begin
                        st_nxt.cnt = CNT_BOTTOM;
                    end
                    else
                    begin
                        st_nxt.cnt = st_r.cnt + CNT_ONE;
                    end
                    if (top && !match)
                    begin
                        st_nxt.ovf = 1'b1;
                    end
                end
                TMR8_FAST:
                begin
                    st_nxt.cnt = st_r.cnt + CNT_ONE;
                    if (top)
                    begin
                        st_nxt.ovf = 1'b1;
                        st_nxt.ocr = st_r.ocb;
                        // Wrap action; match below wins when both fall
                        if (st_r.com == COM_CLEAR)
                        begin
                            st_nxt.oc = 1'b1;
                        end
                        else if (st_r.com == COM_SET)
                        begin
                            st_nxt.oc = 1'b0;
                        end
                    end
                end
                TMR8_PHASE:
                begin
                    // Dual slope: MAX and BOTTOM each held one tick
                    if (!st_r.dn)
                    begin
                        if (top)
                        begin
                            st_nxt.dn  = 1'b1;
                            st_nxt.cnt = st_r.cnt - CNT_ONE;
                            st_nxt.ocr = st_r.ocb;
                        end
                        else
                        begin
                            st_nxt.cnt = st_r.cnt + CNT_ONE;
                        end
                    end
                    else
                    begin
                        if (st_r.cnt == CNT_BOTTOM)
                        begin
                            st_nxt.dn  = 1'b0;
                            st_nxt.cnt = CNT_ONE;
                        end
                        else
                        begin
                            st_nxt.cnt = st_r.cnt - CNT_ONE;
                            if (st_r.cnt == CNT_ONE)
                            begin
                                st_nxt.ovf = 1'b1;
                            end
                        end
                    end
                end
                default:
                begin
                    st_nxt.cnt = st_r.cnt;
                end
            endcase

            // Compare match: flag and output action
            if (match)
            begin
                st_nxt.cmf = 1'b1;
                case (st_r.wgm)
                    TMR8_FAST:
                    begin
                        // Clear, set or toggle by output mode; mode 0 leaves oc alone
                        st_nxt.oc = tmr8_act(st_r.com, st_r.oc);
                    end
                    TMR8_PHASE:
                    begin
                        if (st_r.com == COM_CLEAR)
                        begin
                            st_nxt.oc = st_r.dn;
                        end
                        else if (st_r.com == COM_SET)
                        begin
                            st_nxt.oc = !st_r.dn;
                        end
                    end
                    default:
                    begin
                        st_nxt.oc = tmr8_act(st_r.com, st_r.oc);
                    end
                endcase
            end
        end

        // Count write beats counting and arms match blocking
        if (cw)
        begin
            st_nxt.cnt = pwdata[7:0];
            st_nxt.blk = 1'b1;
        end

        // Compare write: buffered in PWM, direct otherwise
        if (ow)
        begin
            st_nxt.ocb = pwdata[7:0];
            if (!tmr8_pwm(st_r.wgm))
            begin
                st_nxt.ocr = pwdata[7:0];
            end
        end

        // Control write; output mode takes effect at once, oc kept unless forced
        if (kw)
        begin
            st_nxt.wgm  = tmr8_wgm_e'(pwdata[CTRL_WGM_LSB +: 2]);
            st_nxt.com  = pwdata[CTRL_COM_LSB +: 2];
            st_nxt.dir  = pwdata[CTRL_DIR_BIT];
            st_nxt.port = pwdata[CTRL_PORT_BIT];
            if (!tmr8_pwm(st_r.wgm) && !tmr8_pwm(st_nxt.wgm) && force_hit)
            begin
                // Forced match with the new mode: no flag, no clear
                st_nxt.oc = tmr8_act(st_nxt.com, st_nxt.oc);
            end
        end

        // Read data captured in the setup phase
        if (psel && !penable)
        begin
            case (paddr)
                ADDR_CTRL:
                begin
                    st_nxt.rdata = {25'h0, st_r.port, st_r.dir, 1'b0,
                                    st_r.com, st_r.wgm};
                end
                ADDR_COUNT:
                begin
                    st_nxt.rdata = {24'h0, st_r.cnt};
                end
                ADDR_COMPARE:
                begin
                    st_nxt.rdata = {24'h0, st_r.ocb};
                end
                ADDR_STATUS:
                begin
                    st_nxt.rdata = {29'h0, st_r.oc, st_r.cmf, st_r.ovf};
                end
                default:
                begin
                    st_nxt.rdata = 32'h0;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    // Pin takes the compare output whenever an output mode is set
    always_comb
    begin
        pin_out  = (st_r.com != COM_NONE) ? st_r.oc : st_r.port;
        pin_oe_n = !st_r.dir;
    end

    assign prdata         = st_r.rdata;
    assign overflow_flag  = st_r.ovf;
    assign compare_flag   = st_r.cmf;
    assign compare_output = st_r.oc;

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking tmr8_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_count_write: assert property (
        cw |=> st_r.cnt == $past(pwdata[7:0]))
        else $error("count write not taken");

    a_blocked_match: assert property (
        st_r.blk && timer_tick && !sw |=> !$rose(st_r.cmf))
        else $error("match not blocked after count write");

    a_normal_wrap: assert property (
        timer_tick && !cw && st_r.wgm == TMR8_NORMAL && top
        |=> st_r.cnt == CNT_BOTTOM && st_r.ovf)
        else $error("normal mode wrap or overflow wrong");

    a_clear_top: assert property (
        timer_tick && !cw && !sw && st_r.wgm == TMR8_CLEAR && match
        |=> st_r.cnt == CNT_BOTTOM && st_r.cmf)
        else $error("clear-on-match did not clear");

    a_none_hold: assert property (
        timer_tick && !kw && st_r.com == COM_NONE
        |=> st_r.oc == $past(st_r.oc))
        else $error("output moved with output mode zero");

    a_force_act: assert property (
        force_hit && !timer_tick && !cw && !sw
        && pwdata[CTRL_COM_LSB +: 2] == COM_TOGGLE
        && st_r.wgm == TMR8_NORMAL
        && pwdata[CTRL_WGM_LSB +: 2] == TMR8_NORMAL
        |=> st_r.oc != $past(st_r.oc) && st_r.cnt == $past(st_r.cnt)
        && st_r.cmf == $past(st_r.cmf))
        else $error("force strobe action wrong");

    a_fast_wrap: assert property (
        timer_tick && !cw && !kw && st_r.wgm == TMR8_FAST && top
        && st_r.com == COM_CLEAR && st_r.ocr != CNT_MAX
        |=> st_r.oc && st_r.cnt == CNT_BOTTOM ##1 st_r.wgm != TMR8_FAST
        || st_r.cnt != CNT_MAX)
        else $error("fast PWM wrap action wrong");

    a_buffer_hold: assert property (
        st_r.wgm == TMR8_FAST && !(timer_tick && top) && !kw
        |=> st_r.ocr == $past(st_r.ocr))
        else $error("PWM compare changed off boundary");

    a_mode_keep: assert property (
        kw && !force_hit && !timer_tick |=> st_r.oc == $past(st_r.oc))
        else $error("mode change disturbed output state");

    a_pin_dir: assert property (
        kw |=> pin_oe_n == !$past(pwdata[CTRL_DIR_BIT]))
        else $error("pin direction not from direction bit");

endmodule : tmr8_top

// File: sim/tmr8_pin_load.sv
// Load on the compare timer's pin: resolves the pad level.
// Assumes pin_out and the active-low enable come from tmr8_top.
module tmr8_pin_load (
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------
    // Pad resolution
    // ------------------------------
    // A released pad sinks to the board pull-down level
    assign pin_level = pin_oe_n ? 1'b0 : pin_out;
endmodule : tmr8_pin_load

// File: sim/timer8_compare_waveform_tb.sv
// Self-checking bench for the 8-bit compare timer.
// Assumes tmr8_pkg, tmr8_top and tmr8_pin_load are compiled first.
module timer8_compare_waveform_tb import tmr8_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------
    // Signals and instances
    // ------------------------------
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pclk, timer_tick = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, overflow_flag, compare_flag;
    logic        compare_output, pin_out, pin_oe_n, pin_level;
    int          mismatches = 0, num_checks = 0;

    tmr8_top u_tmr8_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
        .overflow_flag(overflow_flag), .compare_flag(compare_flag),
        .compare_output(compare_output), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
    );
    tmr8_pin_load u_tmr8_pin_load (
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level)
    );

    // Clock at 50 MHz
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; waits for pready, then settles 1 ns
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Access phase lasts until pready is seen high at an edge
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask : rd

    // Timer tick held high for n clock edges
    task automatic tk(input int n);
        @(posedge pclk);
        timer_tick <= 1'b1;
        repeat (n) @(posedge pclk);
        timer_tick <= 1'b0;
        #1;
    endtask : tk

    function automatic logic [31:0] ctl(input logic [1:0] w, input logic [1:0] c,
                                        input logic f, input logic dr, input logic p);
        return {25'h0, p, dr, f, c, w};
    endfunction : ctl

    task automatic wrap_up;
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_reset;
        logic [31:0] q;
        logic        e;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_COUNT, 32'h0);
        rd(ADDR_COMPARE, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        chk({31'h0, pin_oe_n}, 32'h1);
        chk({31'h0, pin_level}, 32'h0);
        apb(1'b0, 8'h10, 32'h0, q, e);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask : t_reset

    task automatic t_normal;
        wr(ADDR_COUNT, 32'hfe);
        repeat (4) @(posedge pclk);
        rd(ADDR_COUNT, 32'hfe);
        tk(2);
        rd(ADDR_COUNT, {24'h0, CNT_BOTTOM});
        chk({31'h0, overflow_flag}, 32'h1);
        tk(1);
        rd(ADDR_COUNT, 32'h1);
        rd(ADDR_STATUS, 32'h3);
        wr(ADDR_STATUS, 32'h3);
        rd(ADDR_STATUS, 32'h0);
    endtask : t_normal

    task automatic t_force;
        wr(ADDR_CTRL, ctl(TMR8_NORMAL, COM_SET, 1'b1, 1'b0, 1'b0));
        chk({31'h0, compare_output}, 32'h1);
        chk({31'h0, pin_level}, 32'h0);
        rd(ADDR_STATUS, 32'h4);
        rd(ADDR_COUNT, 32'h1);
        wr(ADDR_CTRL, ctl(TMR8_NORMAL, COM_SET, 1'b0, 1'b1, 1'b0));
        chk({31'h0, pin_level}, 32'h1);
        wr(ADDR_CTRL, ctl(TMR8_NORMAL, COM_NONE, 1'b0, 1'b1, 1'b1));
        chk({31'h0, pin_level}, 32'h1);
        wr(ADDR_CTRL, ctl(TMR8_NORMAL, COM_NONE, 1'b0, 1'b1, 1'b0));
        chk({31'h0, pin_level}, 32'h0);
        wr(ADDR_CTRL, ctl(TMR8_NORMAL, COM_TOGGLE, 1'b1, 1'b1, 1'b0));
        chk({31'h0, compare_output}, 32'h0);
        wr(ADDR_CTRL, ctl(TMR8_FAST, COM_TOGGLE, 1'b1, 1'b1, 1'b0));
        chk({31'h0, compare_output}, 32'h0);
    endtask : t_force

    task automatic t_clear_match;
        wr(ADDR_CTRL, ctl(TMR8_CLEAR, COM_TOGGLE, 1'b0, 1'b1, 1'b0));
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_COMPARE, 32'h2);
        wr(ADDR_STATUS, 32'h3);
        tk(3);
        rd(ADDR_COUNT, 32'h0);
        rd(ADDR_STATUS, 32'h6);
        chk({31'h0, compare_flag}, 32'h1);
        tk(3);
        chk({31'h0, compare_output}, 32'h0);
        wr(ADDR_STATUS, 32'h3);
        wr(ADDR_COMPARE, 32'h5);
        tk(3);
        wr(ADDR_COMPARE, 32'h1);
        tk(1);
        rd(ADDR_COUNT, 32'h4);
        tk(252);
        rd(ADDR_STATUS, 32'h1);
        tk(2);
        chk({31'h0, compare_output}, 32'h1);
        wr(ADDR_CTRL, ctl(TMR8_CLEAR, COM_NONE, 1'b0, 1'b1, 1'b0));
        tk(2);
        chk({31'h0, compare_output}, 32'h1);
        rd(ADDR_COUNT, 32'h0);
        wr(ADDR_COUNT, 32'h1);
        wr(ADDR_STATUS, 32'h3);
        tk(1);
        rd(ADDR_COUNT, 32'h2);
        rd(ADDR_STATUS, 32'h4);
        wr(ADDR_CTRL, ctl(TMR8_CLEAR, COM_TOGGLE, 1'b1, 1'b1, 1'b0));
        chk({31'h0, compare_output}, 32'h0);
    endtask : t_clear_match

    task automatic t_fast;
        wr(ADDR_CTRL, ctl(TMR8_FAST, COM_CLEAR, 1'b0, 1'b1, 1'b0));
        wr(ADDR_COUNT, 32'hfe);
        wr(ADDR_COMPARE, 32'h10);
        wr(ADDR_STATUS, 32'h3);
        tk(1);
        rd(ADDR_COUNT, {24'h0, CNT_MAX});
        tk(1);
        rd(ADDR_COUNT, 32'h0);
        rd(ADDR_STATUS, 32'h5);
        tk(2);
        rd(ADDR_STATUS, 32'h5);
        tk(15);
        rd(ADDR_STATUS, 32'h3);
        wr(ADDR_STATUS, 32'h3);
        tk(238);
        rd(ADDR_STATUS, 32'h0);
        tk(1);
        rd(ADDR_COUNT, 32'h0);
        chk({31'h0, compare_output}, 32'h1);
        wr(ADDR_CTRL, ctl(TMR8_FAST, COM_SET, 1'b0, 1'b1, 1'b0));
        tk(256);
        chk({31'h0, compare_output}, 32'h0);
        tk(17);
        chk({31'h0, compare_output}, 32'h1);
        wr(ADDR_COMPARE, 32'hff);
        tk(239);
        tk(256);
        tk(128);
        chk({31'h0, compare_output}, 32'h1);
        tk(128);
        chk({31'h0, compare_output}, 32'h1);
        // Compare zero: output high for one tick after each wrap
        wr(ADDR_COMPARE, 32'h0);
        wr(ADDR_CTRL, ctl(TMR8_FAST, COM_CLEAR, 1'b0, 1'b1, 1'b0));
        tk(512);
        chk({31'h0, compare_output}, 32'h1);
        tk(1);
        chk({31'h0, compare_output}, 32'h0);
        // Toggle on match; a new compare waits for the wrap
        wr(ADDR_CTRL, ctl(TMR8_FAST, COM_TOGGLE, 1'b0, 1'b1, 1'b0));
        tk(256);
        chk({31'h0, compare_output}, 32'h1);
        wr(ADDR_COMPARE, 32'h40);
        tk(256);
        chk({31'h0, compare_output}, 32'h1);
        tk(64);
        chk({31'h0, compare_output}, 32'h0);
        wr(ADDR_CTRL, ctl(TMR8_PHASE, COM_NONE, 1'b0, 1'b1, 1'b0));
        wr(ADDR_COUNT, 32'hfe);
        tk(3);
        rd(ADDR_COUNT, 32'hfd);
    endtask : t_fast

    // ------------------------------
    // Main sequence and watchdog
    // ------------------------------
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_normal();
        t_force();
        t_clear_match();
        t_fast();
        wrap_up();
    end

    // Cuts a hang short well after the expected run length
    initial
    begin
        repeat (6000) @(posedge pclk);
        mismatches++;
        wrap_up();
    end
endmodule : timer8_compare_waveform_tb
